/* File: regaccess_pkg.sv */
// constants and types for the process-image register access block
//
// Functional notes
// [R1] control bit 7 selects register mode
// [R2] control bit 6: one write, zero read
// [R3] control bits 5..0 give register number
// [R4] data word: first byte high, second low
// [R5] host supplies write value in output word
// [R6] write acknowledged with bit 6 cleared
// [R7] read acknowledged by echoing control byte
// [R8] read returns addressed register contents
// [R9] host ignores input word after write
// [R10] output word ignored on read requests
// [R11] zero to register 31 re-protects
// [R12] user writes need 0x1235 in register 31
// [R13] user register changes apply after restart
// [R14] bit 7 clear: no register access
// [R15] answer held until control byte changes
package regaccess_pkg;

  // ----------------------------------------
  // control byte layout
  // ----------------------------------------
  localparam int CTRL_MODE_BIT = 7;
  localparam int CTRL_WRITE_BIT = 6;
  localparam int CTRL_NUM_MSB = 5;
  localparam int REG_NUM_W = 6;
  localparam int DATA_W = 16;

  // ----------------------------------------
  // register numbers and values
  // ----------------------------------------
  localparam logic [5:0] REG_UNLOCK = 6'h1F;
  localparam logic [5:0] REG_FEATURE = 6'h20;
  localparam logic [15:0] UNLOCK_CODE = 16'h1235;
  localparam logic [15:0] UNLOCK_RESET = 16'h0000;
  localparam logic [15:0] FEATURE_RESET = 16'h0000;
  localparam logic [15:0] UNMAPPED_READ = 16'h0000;

  typedef enum logic [1:0] {
    ACC_NONE,
    ACC_READ,
    ACC_WRITE
  } access_t;

endpackage

/* File: regaccess_decode.sv */
// splits the control byte into access kind and register number
`timescale 1ns/1ps
`default_nettype none
module regaccess_decode
  import regaccess_pkg::*;
(
  // control byte from host
  input wire logic [7:0] control_byte,
  // decoded request
  output regaccess_pkg::access_t access,
  output logic [regaccess_pkg::REG_NUM_W-1:0] reg_num
);
  import regaccess_pkg::*;

  always_comb
  begin
    // [R1] mode bit gates access
    // [R14] no register access
    if (!control_byte[CTRL_MODE_BIT])
      access = ACC_NONE;
    // [R2] direction bit
    else if (control_byte[CTRL_WRITE_BIT])
      access = ACC_WRITE;
    else
      access = ACC_READ;
  end

  // [R3] register number field
  assign reg_num = control_byte[CTRL_NUM_MSB:0];

endmodule // regaccess_decode
`default_nettype wire

/* File: process_image_register_access.sv */
// register access carried in the cyclic process image
`timescale 1ns/1ps
`default_nettype none
module process_image_register_access
  import regaccess_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // process image from host
  input wire logic [7:0] control_byte,
  input wire logic [7:0] host_data_high,
  input wire logic [7:0] host_data_low,
  // process image to host
  output logic [7:0] status_byte,
  output logic [7:0] device_data_high,
  output logic [7:0] device_data_low,
  // restart request and values in effect
  input wire logic restart,
  output logic [regaccess_pkg::DATA_W-1:0] feature_active,
  output logic write_enabled
);
  import regaccess_pkg::*;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  access_t access;
  logic [REG_NUM_W-1:0] reg_num;
  logic [DATA_W-1:0] host_to_device_word;
  logic [DATA_W-1:0] write_unlock_code;
  logic [DATA_W-1:0] feature_settings;
  logic [7:0] last_control;
  logic new_request;
  logic [DATA_W-1:0] next_read_word;

  regaccess_decode u_decode (
    .control_byte(control_byte),
    .access(access),
    .reg_num(reg_num)
  );

  // [R4] high byte first
  assign host_to_device_word = {host_data_high, host_data_low};

  // a request acts once per new control byte, so a held write is not repeated
  assign new_request = (control_byte != last_control);

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      last_control <= 8'h00;
    else
      last_control <= control_byte;
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  // [R11] zero or any value other than the code re-protects
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      write_unlock_code <= UNLOCK_RESET;
    else if (new_request && access == ACC_WRITE && reg_num == REG_UNLOCK)
      write_unlock_code <= host_to_device_word;
  end

  assign write_enabled = (write_unlock_code == UNLOCK_CODE);

  // [R12] user writes need the unlock code
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      feature_settings <= FEATURE_RESET;
    else if (new_request && access == ACC_WRITE && reg_num == REG_FEATURE && write_enabled)
      feature_settings <= host_to_device_word;
  end

  // [R13] stored value takes effect only at restart
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      feature_active <= FEATURE_RESET;
    else if (restart)
      feature_active <= feature_settings;
  end

  // ----------------------------------------
  // answer
  // ----------------------------------------
  // [R10] output word not read here
  // [R8] read data mux; output word unused on reads
  always_comb
  begin
    unique case (reg_num)
      REG_UNLOCK: next_read_word = write_unlock_code;
      REG_FEATURE: next_read_word = feature_settings;
      default: next_read_word = UNMAPPED_READ;
    endcase
  end

  // [R15] answer registered one cycle after the request, held while unchanged
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      status_byte <= 8'h00;
      device_data_high <= 8'h00;
      device_data_low <= 8'h00;
    end
    else
    begin
      unique case (access)
        // [R7] read echoes control byte
        ACC_READ:
        begin
          status_byte <= control_byte;
          device_data_high <= next_read_word[15:8];
          device_data_low <= next_read_word[7:0];
        end
        // [R6] write ack clears bit 6; data word left as is
        ACC_WRITE:
          status_byte <= control_byte & 8'hBF;
        // [R14] plain process data: status clear
        ACC_NONE:
          status_byte <= 8'h00;
        default:
          status_byte <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  // [R6] write acknowledgement
  a_write_ack: assert property (@(posedge clock) disable iff (reset)
    (control_byte[7] && control_byte[6]) |=> status_byte == ($past(control_byte) & 8'hBF))
    else $error("write ack wrong");

  // [R7] read acknowledgement
  a_read_ack: assert property (@(posedge clock) disable iff (reset)
    (control_byte[7] && !control_byte[6]) |=> status_byte == $past(control_byte))
    else $error("read ack wrong");

  // [R8] read data matches register
  a_read_data: assert property (@(posedge clock) disable iff (reset)
    (control_byte == 8'h9F && $stable(write_unlock_code)) |=>
      {device_data_high, device_data_low} == write_unlock_code)
    else $error("read data wrong");

  // [R12] locked feature register
  a_locked_hold: assert property (@(posedge clock) disable iff (reset)
    !write_enabled |=> $stable(feature_settings))
    else $error("protected register changed");

  // [R11] zero restores protection
  a_zero_locks: assert property (@(posedge clock) disable iff (reset)
    (new_request && control_byte == 8'hDF && host_to_device_word == 16'h0000)
      |=> !write_enabled)
    else $error("protection not restored");

  // [R13] no effect before restart
  a_restart_only: assert property (@(posedge clock) disable iff (reset)
    !restart |=> $stable(feature_active))
    else $error("feature changed without restart");

  // [R14] no access without mode bit
  a_no_access: assert property (@(posedge clock) disable iff (reset)
    !control_byte[7] |=> ($stable(write_unlock_code) && status_byte == 8'h00))
    else $error("access without register mode");

  // [R15] answer held while control stable
  a_answer_hold: assert property (@(posedge clock) disable iff (reset)
    ($stable(control_byte) && control_byte[7] && $past(control_byte[7])) |=>
      $stable(status_byte))
    else $error("answer not held");

  // ----------------------------------------
  // further checks
  // ----------------------------------------
  // [R6] data word untouched by write ack
  a_write_data_keep: assert property (@(posedge clock) disable iff (reset) // [R6]
    (access == ACC_WRITE)
      |=> $stable({device_data_high, device_data_low}))
    else $error("data word changed on write ack");

  // [R6] status never shows direction bit
  a_ack_no_dir: assert property (@(posedge clock) disable iff (reset) // [R6]
    !status_byte[CTRL_WRITE_BIT])
    else $error("status direction bit set");

  // [R1] ack only in register mode
  a_ack_mode: assert property (@(posedge clock) disable iff (reset) // [R1]
    status_byte[CTRL_MODE_BIT]
      |-> $past(control_byte[CTRL_MODE_BIT]))
    else $error("ack without register mode");

  // [R8] feature register read back
  a_read_feature: assert property (@(posedge clock) disable iff (reset) // [R8]
    (access == ACC_READ && reg_num == REG_FEATURE && $stable(feature_settings))
      |=> {device_data_high, device_data_low} == feature_settings)
    else $error("feature read data wrong");

  // [R8] unmapped numbers read as fixed value
  a_read_unmapped: assert property (@(posedge clock) disable iff (reset) // [R8]
    (access == ACC_READ && reg_num != REG_UNLOCK && reg_num != REG_FEATURE)
      |=> {device_data_high, device_data_low} == UNMAPPED_READ)
    else $error("unmapped read data wrong");

  // [R4] high byte carries upper bits
  a_word_order: assert property (@(posedge clock) disable iff (reset) // [R4]
    (access == ACC_READ && reg_num == REG_UNLOCK)
      |=> device_data_high == $past(write_unlock_code[15:8]))
    else $error("data byte order wrong");

  // [R11] code word register stores any value
  a_unlock_store: assert property (@(posedge clock) disable iff (reset) // [R11]
    (new_request && access == ACC_WRITE && reg_num == REG_UNLOCK)
      |=> write_unlock_code == $past(host_to_device_word))
    else $error("code word not stored");

  // [R12] unlocked feature write lands
  a_feature_store: assert property (@(posedge clock) disable iff (reset) // [R12]
    (new_request && access == ACC_WRITE && reg_num == REG_FEATURE && write_enabled)
      |=> feature_settings == $past(host_to_device_word))
    else $error("feature write lost");

  // [R12] code word changes only by its own write
  a_unlock_only_own: assert property (@(posedge clock) disable iff (reset) // [R12]
    !(new_request && access == ACC_WRITE && reg_num == REG_UNLOCK)
      |=> $stable(write_unlock_code))
    else $error("code word changed unexpectedly");

  // [R10] reads never write
  a_read_no_write: assert property (@(posedge clock) disable iff (reset) // [R10]
    (access == ACC_READ)
      |=> ($stable(write_unlock_code) && $stable(feature_settings)))
    else $error("register written on read");

  // [R15] held control byte does not rewrite
  a_held_no_write: assert property (@(posedge clock) disable iff (reset) // [R15]
    !new_request
      |=> ($stable(write_unlock_code) && $stable(feature_settings)))
    else $error("held request repeated");

  // [R15] read data held while request held
  a_data_hold: assert property (@(posedge clock) disable iff (reset) // [R15]
    ($stable(control_byte) && access == ACC_READ
      && $stable(write_unlock_code) && $stable(feature_settings))
      |=> $stable({device_data_high, device_data_low}))
    else $error("read data not held");

  // [R13] restart copies stored value
  a_restart_copy: assert property (@(posedge clock) disable iff (reset) // [R13]
    restart |=> feature_active == $past(feature_settings))
    else $error("restart did not apply value");

  // [R14] plain process data leaves data word alone
  a_mode_off_data: assert property (@(posedge clock) disable iff (reset) // [R14]
    !control_byte[CTRL_MODE_BIT]
      |=> $stable({device_data_high, device_data_low}))
    else $error("data word changed outside register mode");

endmodule // process_image_register_access
`default_nettype wire

/* File: host_coupler.sv */
// host side model that drives the process image into the device
`timescale 1ns/1ps
`default_nettype none
module host_coupler
(
  // clock
  input wire logic clock,
  // request from bench
  input wire logic [7:0] req_ctrl,
  input wire logic [15:0] req_word,
  // process image pins
  output var logic [7:0] control_byte = 8'h00,
  output var logic [7:0] host_data_high = 8'h00,
  output var logic [7:0] host_data_low = 8'h00
);
  // control byte and write value
  // reads carry a toggling word, so a device that uses it shows up
  always @(posedge clock)
  begin
    control_byte <= req_ctrl;
    if (req_ctrl[6])
      {host_data_high, host_data_low} <= req_word;
    else
      {host_data_high, host_data_low} <= ~{host_data_high, host_data_low};
  end
endmodule // host_coupler
`default_nettype wire

/* File: process_image_register_access_tb.sv */
// self-checking bench for the process image register access block
`timescale 1ns/1ps
`default_nettype none
module process_image_register_access_tb;
  import regaccess_pkg::*;
  typedef struct packed {logic [7:0] c; logic [15:0] w; logic [7:0] s; logic [15:0] d;
    logic rd; logic we;} row_t;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic restart = 1'b0;
  logic [7:0] req_ctrl = 8'h00;
  logic [15:0] req_word = 16'h0000;
  wire logic [7:0] control_byte, host_data_high, host_data_low;
  logic [7:0] status_byte, device_data_high, device_data_low;
  logic [15:0] feature_active;
  logic write_enabled;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;
  // write after a read needs no spacer; equal bytes never follow each other
  row_t rows [9] = '{
    '{8'hDF, 16'h1235, 8'h9F, 16'h0000, 1'b0, 1'b1},
    '{8'h9F, 16'h0000, 8'h9F, 16'h1235, 1'b1, 1'b1},
    '{8'hE0, 16'h0002, 8'hA0, 16'h0000, 1'b0, 1'b1},
    '{8'hA0, 16'h0000, 8'hA0, 16'h0002, 1'b1, 1'b1},
    '{8'h00, 16'h0000, 8'h00, 16'h0000, 1'b0, 1'b1},
    '{8'hDF, 16'h0000, 8'h9F, 16'h0000, 1'b0, 1'b0},
    '{8'hE0, 16'h00FF, 8'hA0, 16'h0000, 1'b0, 1'b0},
    '{8'hA0, 16'h0000, 8'hA0, 16'h0002, 1'b1, 1'b0},
    '{8'h89, 16'h0000, 8'h89, 16'h0000, 1'b1, 1'b0}};

  always #25 clock = ~clock;

  host_coupler i_host (.clock(clock), .req_ctrl(req_ctrl), .req_word(req_word),
    .control_byte(control_byte), .host_data_high(host_data_high),
    .host_data_low(host_data_low));

  process_image_register_access i_dut (.clock(clock), .reset(reset),
    .control_byte(control_byte), .host_data_high(host_data_high),
    .host_data_low(host_data_low), .status_byte(status_byte),
    .device_data_high(device_data_high), .device_data_low(device_data_low),
    .restart(restart), .feature_active(feature_active), .write_enabled(write_enabled));

  task automatic cmp_word(input string n, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // a hang counts as a mismatch
  always @(posedge clock)
  begin
    cycles++;
    if (cycles > 3000)
    begin
      mismatches++;
      end_sim();
    end
  end

  initial
  begin
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    @(negedge clock);
    cmp_word("reset status", 16'h0000, {8'h00, status_byte});
    cmp_word("reset feature", 16'h0000, feature_active);
    $display("test reset done");
    foreach (rows[i])
    begin
      @(posedge clock);
      req_ctrl <= rows[i].c;
      req_word <= rows[i].w;
      repeat (3) @(posedge clock);
      @(negedge clock);
      cmp_word("status", {8'h00, rows[i].s}, {8'h00, status_byte});
      if (rows[i].rd)
        cmp_word("read data", rows[i].d, {device_data_high, device_data_low});
      cmp_word("write enable", {15'h0, rows[i].we}, {15'h0, write_enabled});
      $display("test row %0d done", i);
    end
    repeat (3) @(negedge clock);
    cmp_word("held status", 16'h0089, {8'h00, status_byte});
    cmp_word("held data", 16'h0000, {device_data_high, device_data_low});
    cmp_word("feature before restart", 16'h0000, feature_active);
    @(posedge clock);
    restart <= 1'b1;
    @(posedge clock);
    restart <= 1'b0;
    repeat (2) @(negedge clock);
    cmp_word("feature after restart", 16'h0002, feature_active);
    $display("test restart done");
    end_sim();
  end
endmodule // process_image_register_access_tb
`default_nettype wire
